// ===== hw/aph_pkg.sv
// Purpose: shared constants for the parallel converter host port
// Assumes: clk_sys at 125 MHz, all pin inputs synchronous to it
// Notes:   both ends and the link interface use these names
package aph_pkg;
  localparam int DATA_W     = 12;
  localparam int REG_W      = 10;
  localparam int PIPE_LAT   = 5;
  localparam int MARK_BASE  = 7;
  localparam int SCAN_CHANS = 2;
  localparam int MARK_W     = 4;

  // register addresses on the two top data lines
  localparam int ADDR_LO_BIT = 10;
  localparam int ADDR_HI_BIT = 11;
  localparam logic [1:0] ADDR_CFG_A = 2'h0;
  localparam logic [1:0] ADDR_CFG_B = 2'h1;

  // config_word_a fields
  localparam int A_REF_SRC  = 0;
  localparam int A_PWR_DOWN = 2;
  localparam int A_PICK_LO  = 3;
  localparam int A_PICK_HI  = 4;
  localparam int A_DIFF_LO  = 5;
  localparam int A_DIFF_HI  = 6;
  localparam int A_ROTATE   = 7;
  localparam int A_CHECK_LO = 8;
  localparam int A_CHECK_HI = 9;

  // config_word_b fields
  localparam int B_SOFT_RST = 0;
  localparam int B_MRK_RST  = 1;
  localparam int B_RW_MODE  = 6;
  localparam int B_FORMAT   = 7;
  localparam int B_ZERO_TRM = 8;
  localparam int B_RDBACK   = 9;

  localparam logic [REG_W-1:0] CFG_A_RST  = 10'h020;
  localparam logic [REG_W-1:0] CFG_B_RST  = 10'h000;
  localparam logic [REG_W-1:0] CFG_A_KEEP = 10'h3fd;
  localparam logic [REG_W-1:0] CFG_B_KEEP = 10'h3c0;

  // output codes; twos complement differs from binary in the msb only
  localparam logic [DATA_W-1:0] CODE_TOP = 12'hfff;
  localparam logic [DATA_W-1:0] CODE_MID = 12'h800;
  localparam logic [DATA_W-1:0] CODE_BOT = 12'h000;

  // timing
  localparam int CLK_MHZ       = 125;
  localparam int CONV_RATE_KSPS = 8000;
  localparam int CONV_HALF_CYC =
    (CLK_MHZ * 1000 + 2 * CONV_RATE_KSPS - 1) / (2 * CONV_RATE_KSPS);
  localparam int STROBE_NS     = 24;
  localparam int STROBE_CYC    = (STROBE_NS * CLK_MHZ + 999) / 1000;
endpackage

// ===== hw/aph_link_if.sv
// Purpose: pins between the converter end and the processor end
// Assumes: one clock domain, clk_sys, for both ends
// Notes:   data bus level resolved from the two output enables
interface aph_link_if;
  logic                        sample_clock_in;
  logic                        chip_select_a_n;
  logic                        chip_select_b;
  logic                        read_strobe_n;
  logic                        write_n;
  logic [aph_pkg::DATA_W-1:0]  host_d;
  logic                        host_d_oe_n;
  logic [aph_pkg::DATA_W-1:0]  dev_d;
  logic                        dev_d_oe_n;
  logic [aph_pkg::DATA_W-1:0]  data;
  logic                        channel_one_marker;

  // undriven bus reads as zero
  assign data = !dev_d_oe_n ? dev_d :
                (!host_d_oe_n ? host_d : aph_pkg::CODE_BOT);

  modport dev (
    input  sample_clock_in,
    input  chip_select_a_n,
    input  chip_select_b,
    input  read_strobe_n,
    input  write_n,
    input  data,
    output dev_d,
    output dev_d_oe_n,
    output channel_one_marker
  );

  modport host (
    output sample_clock_in,
    output chip_select_a_n,
    output chip_select_b,
    output read_strobe_n,
    output write_n,
    output host_d,
    output host_d_oe_n,
    input  data,
    input  channel_one_marker
  );
endinterface

// ===== hw/aph_host_end.sv
// Purpose: processor end; makes the conversion clock, writes and reads
// Assumes: one command at a time, taken only while cmd_busy is low
// Notes:   tracks the read/write pin mode it last programmed
module aph_host_end (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  aph_link_if.host                         link,
  input  wire logic                        cmd_write,
  input  wire logic                        cmd_read,
  input  wire logic [1:0]                  cmd_addr,
  input  wire logic [aph_pkg::REG_W-1:0]   cmd_data,
  output logic                             cmd_busy,
  output logic                             cmd_refused,
  output logic [aph_pkg::DATA_W-1:0]       rd_data,
  output logic                             rd_marker,
  output logic                             rd_valid
);
  typedef enum logic [2:0] {
    APH_IDLE  = 3'b001,
    APH_WRITE = 3'b010,
    APH_READ  = 3'b100
  } aph_hstate_t;

  typedef struct packed {
    aph_hstate_t                 state;
    logic [3:0]                  div_cnt;
    logic                        sclk;
    logic [3:0]                  cnt;
    logic                        csa_n;
    logic                        csb;
    logic                        rd_n;
    logic                        wr_n;
    logic [aph_pkg::DATA_W-1:0]  hd;
    logic                        hd_oe_n;
    logic                        rw_mode;
    logic                        rw_pend;
    logic                        init_done;
    logic                        busy;
    logic                        refused;
    logic [aph_pkg::DATA_W-1:0]  rdata;
    logic                        rmark;
    logic                        rvalid;
  } aph_host_st_t;

  aph_host_st_t s_r;
  aph_host_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.refused = 1'b0;
    s_nxt.rvalid  = 1'b0;
    // conversion clock at or below 8 MSPS
    if (s_r.div_cnt == 4'(aph_pkg::CONV_HALF_CYC - 1)) begin
      s_nxt.div_cnt = 4'h0;
      s_nxt.sclk    = !s_r.sclk;
    end else begin
      s_nxt.div_cnt = s_r.div_cnt + 4'h1;
    end
    unique case (s_r.state)
      APH_IDLE: begin
        if (cmd_write) begin
          if (cmd_addr[1]) begin
            s_nxt.refused = 1'b1;
          end else begin
            // value on low lines, address on top two
            s_nxt.hd      = {cmd_addr, cmd_data};
            s_nxt.hd_oe_n = 1'b0;
            s_nxt.csa_n   = 1'b0;
            s_nxt.csb     = 1'b1;
            // write low in either pin mode
            s_nxt.wr_n    = 1'b0;
            s_nxt.cnt     = 4'(aph_pkg::STROBE_CYC - 1);
            s_nxt.rw_pend = (cmd_addr == aph_pkg::ADDR_CFG_B) ?
                            cmd_data[aph_pkg::B_RW_MODE] : s_r.rw_mode;
            s_nxt.busy    = 1'b1;
            s_nxt.state   = APH_WRITE;
          end
        end else if (cmd_read) begin
          // no read before the first write
          if (!s_r.init_done) begin
            s_nxt.refused = 1'b1;
          end else begin
            s_nxt.csa_n = 1'b0;
            s_nxt.csb   = 1'b1;
            // separate read input only in write-strobe mode
            s_nxt.rd_n  = s_r.rw_mode;
            s_nxt.wr_n  = 1'b1;
            s_nxt.cnt   = 4'(aph_pkg::STROBE_CYC - 1);
            s_nxt.busy  = 1'b1;
            s_nxt.state = APH_READ;
          end
        end
      end
      APH_WRITE, APH_READ: begin
        if (s_r.cnt != 4'h0) begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end else begin
          if (s_r.state == APH_READ) begin
            s_nxt.rdata  = link.data;
            s_nxt.rmark  = link.channel_one_marker;
            s_nxt.rvalid = 1'b1;
          end else begin
            s_nxt.init_done = 1'b1;
            s_nxt.rw_mode   = s_r.rw_pend;
          end
          s_nxt.csa_n   = 1'b1;
          s_nxt.csb     = 1'b0;
          s_nxt.rd_n    = 1'b1;
          s_nxt.wr_n    = 1'b1;
          s_nxt.hd_oe_n = 1'b1;
          s_nxt.busy    = 1'b0;
          s_nxt.state   = APH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_r         <= '0;
      s_r.state   <= APH_IDLE;
      s_r.csa_n   <= 1'b1;
      s_r.rd_n    <= 1'b1;
      s_r.wr_n    <= 1'b1;
      s_r.hd_oe_n <= 1'b1;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign link.sample_clock_in = s_r.sclk;
  assign link.chip_select_a_n = s_r.csa_n;
  assign link.chip_select_b   = s_r.csb;
  assign link.read_strobe_n   = s_r.rd_n;
  assign link.write_n         = s_r.wr_n;
  assign link.host_d          = s_r.hd;
  assign link.host_d_oe_n     = s_r.hd_oe_n;
  assign cmd_busy             = s_r.busy;
  assign cmd_refused          = s_r.refused;
  assign rd_data              = s_r.rdata;
  assign rd_marker            = s_r.rmark;
  assign rd_valid             = s_r.rvalid;
endmodule

// ===== hw/aph_dev_end.sv
// Purpose: converter end; result pipeline, marker, config registers
// Assumes: pin inputs synchronous to clk_sys; raw codes are offset binary
// Notes:   conv_diff carries the core's differential result
//
// How it works
// - each falling sample clock edge outside power down yields a result
// - single input keeps channel marker inactive
// - host keeps single-channel rate at or below 8 MSPS
// - host gives at most 4 MSPS per channel with two
// - two channels: marker low for channel 1
// - config_word_b bit 7 picks result coding
// - single-ended binary codes fff, 800, 000
// - single-ended twos complement codes 7ff, 000, 800
// - differential binary codes fff, 800, 000
// - differential twos complement codes 7ff, 000, 800
// - two ten-bit configuration registers
// - config_word_a field layout bits 9 to 0
// - config_word_b field layout bits 9 to 0
// - write value taken from data lines 0-9
// - lines 10-11 address the register written
// - read strobe combines both selects and read; in read/write mode, both selects and write pin high
// - result latency five conversion clock cycles
// - marker restart delays first marker seven plus channels
// - host's first access is a write
// - write pin is read/write or write strobe
module aph_dev_end #(
  parameter int PIPE_DEPTH = aph_pkg::PIPE_LAT
) (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  aph_link_if.dev                          link,
  input  wire logic [aph_pkg::DATA_W-1:0]  conv_pos,
  input  wire logic [aph_pkg::DATA_W-1:0]  conv_neg,
  input  wire logic [aph_pkg::DATA_W-1:0]  conv_diff,
  output logic [aph_pkg::REG_W-1:0]        config_a_out,
  output logic [aph_pkg::REG_W-1:0]        config_b_out,
  output logic [aph_pkg::DATA_W-1:0]       result_out,
  output logic                             result_ch1,
  output logic                             result_strobe
);
  localparam int TAG_W = aph_pkg::DATA_W + 1;
  localparam logic [aph_pkg::MARK_W-1:0] MARK_LOAD =
    aph_pkg::MARK_W'(aph_pkg::MARK_BASE + aph_pkg::SCAN_CHANS);

  typedef struct packed {
    logic [aph_pkg::REG_W-1:0]         cfg_a;
    logic [aph_pkg::REG_W-1:0]         cfg_b;
    logic [1:0]                        last_addr;
    logic                              sclk_prev;
    logic                              wr_prev;
    logic [PIPE_DEPTH-1:0][TAG_W-1:0]  pipe;
    logic [aph_pkg::DATA_W-1:0]        out_code;
    logic                              out_ch1;
    logic                              phase;
    logic [aph_pkg::MARK_W-1:0]        mark_cnt;
    logic [aph_pkg::DATA_W-1:0]        d_r;
    logic                              d_oe_n;
    logic                              marker;
    logic                              res_strobe;
  } aph_dev_st_t;

  aph_dev_st_t s_r;
  aph_dev_st_t s_nxt;

  // select pair: a low, b high
  function automatic logic aph_selected(input logic csa_n, input logic csb);
    return !csa_n && csb;
  endfunction

  logic                        rd_act;
  logic                        wr_act;
  logic                        fall;
  logic                        two_ch;
  logic                        new_ch1;
  logic [aph_pkg::DATA_W-1:0]  new_code;
  logic [aph_pkg::DATA_W-1:0]  wdata;

  always_comb begin
    s_nxt = s_r;
    s_nxt.res_strobe = 1'b0;
    wdata = link.data;
    // read/write pin mode or write strobe with separate read
    if (s_r.cfg_b[aph_pkg::B_RW_MODE]) begin
      rd_act = aph_selected(link.chip_select_a_n, link.chip_select_b) && link.write_n;
      wr_act = aph_selected(link.chip_select_a_n, link.chip_select_b) && !link.write_n;
    end else begin
      rd_act = aph_selected(link.chip_select_a_n, link.chip_select_b) &&
               !link.read_strobe_n;
      wr_act = aph_selected(link.chip_select_a_n, link.chip_select_b) && !link.write_n;
    end
    s_nxt.wr_prev   = wr_act;
    fall            = s_r.sclk_prev && !link.sample_clock_in;
    s_nxt.sclk_prev = link.sample_clock_in;
    two_ch          = s_r.cfg_a[aph_pkg::A_ROTATE];

    // channel 1 then channel 2 in rotation
    // diff and pick bits pick source
    if (two_ch) begin
      new_ch1  = !s_r.phase;
      new_code = s_r.phase ? conv_neg : conv_pos;
    end else if (s_r.cfg_a[aph_pkg::A_DIFF_LO]) begin
      new_ch1  = 1'b1;
      new_code = conv_diff;
    end else begin
      new_ch1  = 1'b1;
      new_code = s_r.cfg_a[aph_pkg::A_PICK_LO] ? conv_neg : conv_pos;
    end

    // new result on every falling edge while not powered down
    if (fall && !s_r.cfg_a[aph_pkg::A_PWR_DOWN]) begin
      s_nxt.pipe       = {s_r.pipe[PIPE_DEPTH-2:0], {new_ch1, new_code}};
      s_nxt.out_code   = s_r.pipe[PIPE_DEPTH-1][aph_pkg::DATA_W-1:0];
      s_nxt.out_ch1    = s_r.pipe[PIPE_DEPTH-1][aph_pkg::DATA_W];
      s_nxt.phase      = two_ch && !s_r.phase;
      s_nxt.res_strobe = 1'b1;
      if (s_r.mark_cnt != '0) begin
        s_nxt.mark_cnt = s_r.mark_cnt - 1'b1;
      end
    end

    if (wr_act && !s_r.wr_prev) begin
      unique case ({wdata[aph_pkg::ADDR_HI_BIT], wdata[aph_pkg::ADDR_LO_BIT]})
        aph_pkg::ADDR_CFG_A: begin
          s_nxt.cfg_a     = wdata[aph_pkg::REG_W-1:0] & aph_pkg::CFG_A_KEEP;
          s_nxt.last_addr = aph_pkg::ADDR_CFG_A;
        end
        aph_pkg::ADDR_CFG_B: begin
          // reserved bits zero, restart bits self-clear
          s_nxt.cfg_b     = wdata[aph_pkg::REG_W-1:0] & aph_pkg::CFG_B_KEEP;
          s_nxt.last_addr = aph_pkg::ADDR_CFG_B;
          if (wdata[aph_pkg::B_MRK_RST]) begin
            s_nxt.mark_cnt = MARK_LOAD;
            s_nxt.phase    = 1'b0;
            s_nxt.pipe     = '0;
          end
          if (wdata[aph_pkg::B_SOFT_RST]) begin
            s_nxt.cfg_a    = aph_pkg::CFG_A_RST;
            s_nxt.cfg_b    = aph_pkg::CFG_B_RST;
            s_nxt.mark_cnt = MARK_LOAD;
            s_nxt.phase    = 1'b0;
            s_nxt.pipe     = '0;
          end
        end
        default: begin
          // reserved codes write nothing
        end
      endcase
    end

    if (s_r.cfg_b[aph_pkg::B_RDBACK]) begin
      s_nxt.d_r = {s_r.last_addr, (s_r.last_addr == aph_pkg::ADDR_CFG_B) ?
                   s_r.cfg_b : s_r.cfg_a};
    end else if (s_r.cfg_b[aph_pkg::B_FORMAT]) begin
      s_nxt.d_r = s_nxt.out_code ^ aph_pkg::CODE_MID;
    end else begin
      s_nxt.d_r = s_nxt.out_code;
    end
    s_nxt.d_oe_n = !rd_act;

    // marker low while channel 1 result is out
    s_nxt.marker = !(s_nxt.cfg_a[aph_pkg::A_ROTATE] && s_nxt.mark_cnt == '0 &&
                     s_nxt.out_ch1);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_r          <= '0;
      s_r.cfg_a    <= aph_pkg::CFG_A_RST;
      s_r.cfg_b    <= aph_pkg::CFG_B_RST;
      s_r.mark_cnt <= MARK_LOAD;
      s_r.d_oe_n   <= 1'b1;
      s_r.marker   <= 1'b1;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign link.dev_d              = s_r.d_r;
  assign link.dev_d_oe_n         = s_r.d_oe_n;
  assign link.channel_one_marker = s_r.marker;
  assign config_a_out            = s_r.cfg_a;
  assign config_b_out            = s_r.cfg_b;
  assign result_out              = s_r.out_code;
  assign result_ch1              = s_r.out_ch1;
  assign result_strobe           = s_r.res_strobe;
endmodule

// ===== tb/aph_link_asserts.sv
// Purpose: pin checks on the link between the two ends
// Assumes: one clock clk_sys, synchronous active high reset
// Notes:   instanced beside the link by the bench
module aph_link_asserts (
  input wire logic                        clk_sys,
  input wire logic                        reset,
  input wire logic                        sample_clock_in,
  input wire logic                        chip_select_a_n,
  input wire logic                        chip_select_b,
  input wire logic                        write_n,
  input wire logic [aph_pkg::DATA_W-1:0]  host_d,
  input wire logic                        host_d_oe_n,
  input wire logic                        dev_d_oe_n,
  input wire logic                        channel_one_marker
);
  timeunit 1ns;
  timeprecision 1ps;

  logic wr_seen_r;
  logic rd_sel;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  assign rd_sel = !chip_select_a_n && chip_select_b && write_n;

  always_ff @(posedge clk_sys) begin
    if (reset) wr_seen_r <= 1'h0;
    else if (!write_n && !chip_select_a_n) wr_seen_r <= 1'h1;
  end

  sequence wr_start;
    $fell(write_n) && !chip_select_a_n;
  endsequence
  sequence wr_hold;
    (!write_n && $stable(host_d))[*2] ##1 write_n;
  endsequence

  wr_hold_a: assert property (wr_start |=> wr_hold)
    else $error("write strobe or data not held");
  wr_addr_a: assert property (wr_start |-> !host_d[11] && !host_d_oe_n)
    else $error("write to reserved address");
  first_write_a: assert property ($fell(chip_select_a_n) |-> !write_n || wr_seen_r)
    else $error("read before first write");
  oe_cause_a: assert property ($fell(dev_d_oe_n) |-> $past(rd_sel))
    else $error("device drove bus without read");
  oe_width_a: assert property ($fell(dev_d_oe_n) |-> !dev_d_oe_n[*3] ##1 dev_d_oe_n)
    else $error("device drive length wrong");
  oe_release_a: assert property ($rose(chip_select_a_n) |=> dev_d_oe_n)
    else $error("bus not released after select");
  no_clash_a: assert property (!(!dev_d_oe_n && !host_d_oe_n))
    else $error("both ends drive the bus");
  conv_rate_a: assert property ($changed(sample_clock_in) |=> $stable(sample_clock_in)[*7])
    else $error("conversion clock too fast");
  marker_alt_a: assert property ($fell(channel_one_marker) |-> ##[1:40] channel_one_marker)
    else $error("marker not alternating");
endmodule

// ===== tb/aph_bench.sv
// Purpose: self-checking bench joining host end and device end
// Assumes: clk_sys 125 MHz, reset held 12 cycles
// Notes:   each scenario is its own task
module aph_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys   = 1'h0;
  logic        reset     = 1'h1;
  logic        clk_en    = 1'h1;
  logic        cmd_write = 1'h0;
  logic        cmd_read  = 1'h0;
  logic [1:0]  cmd_addr  = 2'h0;
  logic [9:0]  cmd_data  = 10'h000;
  logic [11:0] conv_pos  = 12'h000;
  logic [11:0] conv_neg  = 12'h000;
  logic [11:0] conv_diff = 12'h000;
  logic        cmd_busy, cmd_refused, rd_marker, rd_valid, result_ch1, result_strobe;
  logic [11:0] rd_data, result_out;
  logic [9:0]  config_a_out, config_b_out;
  logic        refd;
  int          num_errors = 0;
  int          checks = 0;

  always #4 clk_sys = ~clk_sys;

  aph_link_if link ();
  aph_host_end aph_host_end_inst (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .link(link), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_busy(cmd_busy), .cmd_refused(cmd_refused),
    .rd_data(rd_data), .rd_marker(rd_marker), .rd_valid(rd_valid));
  aph_dev_end #(.PIPE_DEPTH(aph_pkg::PIPE_LAT)) aph_dev_end_inst (.clk_sys(clk_sys),
    .reset(reset), .clk_en(clk_en), .link(link), .conv_pos(conv_pos),
    .conv_neg(conv_neg), .conv_diff(conv_diff), .config_a_out(config_a_out),
    .config_b_out(config_b_out), .result_out(result_out), .result_ch1(result_ch1),
    .result_strobe(result_strobe));
  aph_link_asserts aph_link_asserts_inst (.clk_sys(clk_sys), .reset(reset),
    .sample_clock_in(link.sample_clock_in), .chip_select_a_n(link.chip_select_a_n),
    .chip_select_b(link.chip_select_b), .write_n(link.write_n), .host_d(link.host_d),
    .host_d_oe_n(link.host_d_oe_n), .dev_d_oe_n(link.dev_d_oe_n),
    .channel_one_marker(link.channel_one_marker));

  task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic access(input logic w, input logic [1:0] a, input logic [9:0] d);
    @(posedge clk_sys);
    cmd_write <= w;
    cmd_read <= !w;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge clk_sys);
    cmd_write <= 1'h0;
    cmd_read <= 1'h0;
    #1 refd = cmd_refused;
    for (int i = 0; i < 20; i++) begin
      if (refd || (w ? !cmd_busy : rd_valid)) break;
      @(posedge clk_sys);
      #1;
    end
    cmp_flag(refd || (w ? !cmd_busy : rd_valid), 1'h1, "access done");
  endtask

  task automatic wait_strobe;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      #1;
      if (result_strobe) break;
    end
  endtask

  task automatic t_reset;
    @(posedge clk_sys);
    #1;
    cmp_val({2'h0, config_a_out}, {2'h0, aph_pkg::CFG_A_RST}, "cfg a reset");
    cmp_val({2'h0, config_b_out}, {2'h0, aph_pkg::CFG_B_RST}, "cfg b reset");
    $display("test reset done");
  endtask

  task automatic t_refuse;
    access(1'h0, 2'h0, 10'h000);
    cmp_flag(refd, 1'h1, "early read");
    access(1'h1, 2'h2, 10'h3ff);
    cmp_flag(refd, 1'h1, "addr 2 write");
    access(1'h1, 2'h3, 10'h3ff);
    cmp_flag(refd, 1'h1, "addr 3 write");
    cmp_val({2'h0, config_a_out}, {2'h0, aph_pkg::CFG_A_RST}, "cfg a kept");
    $display("test refuse done");
  endtask

  task automatic t_regs;
    access(1'h1, 2'h0, 10'h2a5);
    cmp_val({2'h0, config_a_out}, 12'h2a5, "cfg a write");
    access(1'h1, 2'h1, 10'h1c0);
    cmp_val({2'h0, config_b_out}, 12'h1c0, "cfg b write");
    access(1'h1, 2'h1, 10'h03e);
    cmp_val({2'h0, config_b_out}, 12'h000, "cfg b reserved");
    access(1'h1, 2'h1, 10'h001);
    cmp_val({2'h0, config_a_out}, {2'h0, aph_pkg::CFG_A_RST}, "soft reset");
    $display("test regs done");
  endtask

  task automatic t_codes;
    logic [11:0] code;
    logic [11:0] bin [3] = '{12'hfff, 12'h800, 12'h000};
    logic [11:0] twos [3] = '{12'h7ff, 12'h000, 12'h800};
    logic        f;
    for (int i = 0; i < 12; i++) begin
      code = bin[i % 3];
      f = ((i / 3) % 2) == 1;
      @(posedge clk_sys);
      conv_pos <= (i < 6) ? code : ~code;
      conv_neg <= ~code;
      conv_diff <= (i < 6) ? ~code : code;
      access(1'h1, 2'h0, (i < 6) ? 10'h000 : 10'h020);
      access(1'h1, 2'h1, {2'h0, f, i[0], 6'h00});
      repeat (120) @(posedge clk_sys);
      access(1'h0, 2'h0, 10'h000);
      cmp_val(rd_data, f ? twos[i % 3] : code, "coded result");
      cmp_flag(rd_marker, 1'h1, "single marker");
    end
    $display("test codes done");
  endtask

  task automatic t_latency;
    int n = 0;
    access(1'h1, 2'h0, 10'h000);
    access(1'h1, 2'h1, 10'h000);
    repeat (120) @(posedge clk_sys);
    wait_strobe;
    repeat (4) @(posedge clk_sys);
    conv_pos <= 12'habc;
    for (int i = 0; i < 200; i++) begin
      wait_strobe;
      n++;
      if (result_out === 12'habc) break;
    end
    cmp_val(12'(n), 12'(aph_pkg::PIPE_LAT + 1), "latency edges");
    $display("test latency done");
  endtask

  task automatic t_dual;
    int   n = 0;
    logic last;
    @(posedge clk_sys);
    conv_pos <= 12'h111;
    conv_neg <= 12'h222;
    access(1'h1, 2'h0, 10'h088);
    access(1'h1, 2'h1, 10'h002);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      #1;
      if (result_strobe) n++;
      if (!link.channel_one_marker) break;
    end
    cmp_flag(n >= aph_pkg::MARK_BASE + aph_pkg::SCAN_CHANS - 1 &&
             n <= aph_pkg::MARK_BASE + aph_pkg::SCAN_CHANS + 1, 1'h1, "marker delay");
    last = result_ch1;
    for (int k = 0; k < 4; k++) begin
      wait_strobe;
      cmp_flag(result_ch1, !last, "channel order");
      last = result_ch1;
    end
    for (int k = 0; k < 4; k++) begin
      access(1'h0, 2'h0, 10'h000);
      cmp_val(rd_data, rd_marker ? 12'h222 : 12'h111, "marker tag");
    end
    $display("test dual done");
  endtask

  task automatic t_modes;
    int n = 0;
    access(1'h1, 2'h0, 10'h004);
    repeat (48) begin
      @(posedge clk_sys);
      #1;
      if (result_strobe) n++;
    end
    cmp_val(12'(n), 12'h000, "power down strobes");
    @(posedge clk_sys);
    conv_pos <= 12'h123;
    conv_neg <= 12'h5a5;
    access(1'h1, 2'h0, 10'h008);
    repeat (120) @(posedge clk_sys);
    access(1'h0, 2'h0, 10'h000);
    cmp_val(rd_data, 12'h5a5, "second input");
    access(1'h1, 2'h1, 10'h200);
    access(1'h0, 2'h0, 10'h000);
    cmp_val(rd_data, {aph_pkg::ADDR_CFG_B, 10'h200}, "readback");
    access(1'h1, 2'h1, 10'h000);
    $display("test modes done");
  endtask

  task automatic stop_test;
    $display("counts: checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test;
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'h0;
    t_reset;
    t_refuse;
    t_regs;
    t_codes;
    t_latency;
    t_modes;
    t_dual;
    stop_test;
  end
endmodule
